//--- dv/umd_decoder_asserts.sv
/* Port checker for the memory map decoder, bound to its top.
   Assumes one clock and no fetch together with a data access. */
`timescale 1ns/100ps
`default_nettype none
module umd_decoder_asserts (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic upper_program_enable_in,
    input wire logic [1:0] pointer_width_load_in,
    input wire logic [1:0] pointer_width_value_in,
    input wire logic data_pointer_sel_in,
    input wire umd_pkg::umd_fetch_req_s fetch_req_in,
    input wire umd_pkg::umd_data_req_s data_req_in,
    input wire logic code_sel_out,
    input wire logic [15:0] code_addr_out,
    input wire logic urom_sel_out,
    input wire logic [12:0] urom_addr_out,
    input wire logic fetch_fault_out,
    input wire logic [15:0] load_data_out,
    input wire logic data_fault_out,
    input wire logic [1:0] pointer_width_out,
    input wire logic [1:0] segment_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    wire logic up = upper_program_enable_in; // Upper pages on
    wire logic fv = fetch_req_in.valid && !data_req_in.valid; // Lone fetch
    wire logic [15:0] fa = fetch_req_in.addr; // Fetch address
    wire logic dv = data_req_in.valid; // Data access
    wire logic [15:0] da = data_req_in.addr; // Pointer value
    wire logic dw = pointer_width_out[data_pointer_sel_in]; // Word mode
    a_user_fetch: assert property (fv && !fa[15] |-> code_sel_out && code_addr_out == fa)
        else $error("user fetch misrouted");
    a_rom_fetch: assert property (fv && !up && fa[15:13] == 3'h4 |->
        urom_sel_out && urom_addr_out == fa[12:0]) else $error("rom fetch misrouted");
    a_upper_fetch: assert property (fv && up && fa[15] |->
        code_sel_out && !urom_sel_out && code_addr_out == fa) else $error("upper fetch");
    a_fetch_ok: assert property (fetch_req_in.valid |=> !fetch_fault_out)
        else $error("legal fetch faulted");
    a_seg_user: assert property (fetch_req_in.valid && !fa[15] |=> segment_out == 2'h0)
        else $error("segment not user");
    a_seg_image: assert property (fetch_req_in.valid && !up && fa[15:13] >= 3'h5 |=>
        segment_out == 2'h2) else $error("segment not data");
    a_width_load: assert property (pointer_width_load_in[0] |=>
        pointer_width_out[0] == $past(pointer_width_value_in[0])) else $error("width load");
    a_width_hold: assert property (pointer_width_load_in == 2'h0 |=>
        $stable(pointer_width_out)) else $error("width moved");
    a_byte_zero: assert property (dv && !data_req_in.write && !dw |=>
        data_fault_out || load_data_out[15:8] == 8'h0) else $error("byte not steered");
    a_data_pages: assert property (segment_out == 2'h2 && dv && !data_req_in.write &&
        !da[15] |-> code_sel_out) else $error("data run pages");
    a_rom_pages: assert property (segment_out == 2'h1 && dv && !data_req_in.write &&
        !fetch_req_in.valid && da[15] |-> code_sel_out && !urom_sel_out)
        else $error("rom run pages");
    a_rom_data: assert property (segment_out == 2'h0 && dv && dw && !data_req_in.write &&
        da[15:13] == 3'h4 |-> urom_sel_out && urom_addr_out == da[12:0])
        else $error("rom data read");
    c_upper: cover property (fv && up && fa[15]);
    c_data_run: cover property (segment_out == 2'h2 && dv);
    c_store: cover property (dv && data_req_in.write);
endmodule // umd_decoder_asserts
bind umd_decoder umd_decoder_asserts chk_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .upper_program_enable_in(upper_program_enable_in), .fetch_req_in(fetch_req_in),
    .pointer_width_load_in(pointer_width_load_in), .data_req_in(data_req_in),
    .pointer_width_value_in(pointer_width_value_in), .code_sel_out(code_sel_out),
    .data_pointer_sel_in(data_pointer_sel_in), .code_addr_out(code_addr_out),
    .urom_sel_out(urom_sel_out), .urom_addr_out(urom_addr_out), .segment_out(segment_out),
    .fetch_fault_out(fetch_fault_out), .load_data_out(load_data_out),
    .data_fault_out(data_fault_out), .pointer_width_out(pointer_width_out));
`default_nettype wire

//--- dv/umd_mem_model.sv
/* Code memory and utility ROM model for the decoder's far side.
   Assumes select and address come combinationally; word is registered. */
`timescale 1ns/100ps
`default_nettype none
module umd_mem_model (
    input wire logic mclk_in,
    input wire logic code_sel_in,
    input wire logic [15:0] code_addr_in,
    input wire logic urom_sel_in,
    input wire logic [12:0] urom_addr_in,
    output logic [15:0] code_rdata_out,
    output logic [15:0] urom_rdata_out
);
    // Known start so the inverted idle pattern is never unknown
    initial begin
        code_rdata_out = 16'h0;
        urom_rdata_out = 16'h0;
    end
    // Word is an address pattern; an unselected memory toggles every cycle
    always @(posedge mclk_in) begin
        code_rdata_out <= code_sel_in ? code_addr_in ^ 16'h5a5a : ~code_rdata_out;
        urom_rdata_out <= urom_sel_in ? {3'h0, urom_addr_in} ^ 16'hc3c3 : ~urom_rdata_out;
    end
endmodule // umd_mem_model
`default_nettype wire

//--- dv/unified_memory_map_decoder_tb.sv
/* Self-checking bench for the memory map decoder with a memory model.
   Assumes the decoder answers one cycle after each request. */
`timescale 1ns/100ps
`default_nettype none
module unified_memory_map_decoder_tb;
    typedef struct packed {logic up; logic [15:0] a; logic [1:0] seg; logic rom;} umd_row_s;
    logic mclk_in = 1'b0, arst_n_in = 1'b0, upper_program_enable_in = 1'b0, psel = 1'b0;
    logic [1:0] code_page_select_in = 2'h0, wload = 2'h0, wval = 2'h0;
    umd_pkg::umd_fetch_req_s fetch_req_in = '0; // Fetch request
    umd_pkg::umd_data_req_s data_req_in = '0; // Data request
    wire logic [15:0] crd, urd, code_addr, fetch_data, load_data;
    wire logic [12:0] urom_addr;
    wire logic code_sel, urom_sel, fetch_fault, data_fault;
    wire logic [1:0] pw, seg;
    int err_total = 0, compares = 0, i, c;
    logic [15:0] ca; // Code address seen in the request cycle
    logic cs, us; // Selects seen in the request cycle
    // Fetch rows: upper enable, address, segment after, ROM answers
    umd_row_s rows [6] = '{'{1'b0, 16'h8000, 2'h1, 1'b1}, '{1'b0, 16'h0010, 2'h0, 1'b0},
        '{1'b1, 16'h8000, 2'h0, 1'b0}, '{1'b1, 16'hc004, 2'h0, 1'b0},
        '{1'b1, 16'ha000, 2'h0, 1'b0}, '{1'b0, 16'h9fff, 2'h1, 1'b1}};
    umd_decoder dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .upper_program_enable_in(upper_program_enable_in),
        .code_page_select_in(code_page_select_in), .pointer_width_load_in(wload),
        .pointer_width_value_in(wval), .data_pointer_sel_in(psel), .fetch_req_in(fetch_req_in),
        .data_req_in(data_req_in), .code_rdata_in(crd), .urom_rdata_in(urd),
        .code_sel_out(code_sel), .code_addr_out(code_addr), .urom_sel_out(urom_sel),
        .urom_addr_out(urom_addr), .fetch_data_out(fetch_data), .fetch_fault_out(fetch_fault),
        .load_data_out(load_data), .data_fault_out(data_fault), .pointer_width_out(pw),
        .segment_out(seg));
    umd_mem_model mem_u (.mclk_in(mclk_in), .code_sel_in(code_sel), .code_addr_in(code_addr),
        .urom_sel_in(urom_sel), .urom_addr_in(urom_addr), .code_rdata_out(crd),
        .urom_rdata_out(urd));
    // Expected memory words, kept apart from the model
    function automatic logic [15:0] cw(input logic [15:0] a);
        return a ^ 16'h5a5a;
    endfunction
    function automatic logic [15:0] rw(input logic [12:0] a);
        return {3'h0, a} ^ 16'hc3c3;
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One fetch; selects sampled in the request cycle, answer after
    task fetch(input logic [15:0] a);
        @(posedge mclk_in) fetch_req_in <= {1'b1, a};
        #1 {cs, us, ca} = {code_sel, urom_sel, code_addr};
        @(posedge mclk_in) fetch_req_in.valid <= 1'b0;
        #1;
    endtask
    // One data access through pointer ps
    task dacc(input logic ps, input logic wr, input logic [15:0] a, input logic [15:0] wd);
        @(posedge mclk_in) begin
            psel <= ps;
            data_req_in <= {1'b1, wr, ps, a, wd};
        end
        #1 {cs, us, ca} = {code_sel, urom_sel, code_addr};
        @(posedge mclk_in) data_req_in.valid <= 1'b0;
        #1;
    endtask
    initial forever #12.5 mclk_in = ~mclk_in;
    // Watchdog well beyond the roughly seventy cycles of the run
    initial begin
        #20000;
        err_total++;
        results();
    end
    initial begin
        repeat (2) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        #1 chk(16'(seg), 16'h1);
        chk(16'(pw), 16'h0);
        for (i = 0; i < 6; i++) begin
            @(posedge mclk_in) upper_program_enable_in <= rows[i].up;
            fetch(rows[i].a);
            chk(16'(seg), 16'(rows[i].seg));
            chk(fetch_data, rows[i].rom ? rw(rows[i].a[12:0]) : cw(rows[i].a));
            chk(16'(us), 16'(rows[i].rom));
            chk(16'(fetch_fault), 16'h0);
        end
        @(posedge mclk_in) {wload, wval} <= 4'ha;
        @(posedge mclk_in) wload <= 2'h0;
        #1 chk(16'(pw), 16'h2);
        fetch(16'h0010);
        dacc(1'b0, 1'b1, 16'h0003, 16'h00ab);
        dacc(1'b0, 1'b1, 16'h0002, 16'h00cd);
        dacc(1'b0, 1'b0, 16'h0003, 16'h0);
        chk(load_data, 16'h00ab);
        dacc(1'b1, 1'b0, 16'h0001, 16'h0);
        chk(load_data, 16'habcd);
        dacc(1'b1, 1'b0, 16'h8002, 16'h0);
        chk(load_data, rw(13'h2));
        @(posedge mclk_in) code_page_select_in <= 2'h1;
        fetch(16'ha001);
        chk(fetch_data, 16'habcd);
        dacc(1'b0, 1'b0, 16'h0001, 16'h0);
        chk(ca, 16'h4000);
        chk(load_data, cw(16'h4000) >> 8);
        dacc(1'b1, 1'b0, 16'ha000, 16'h0);
        chk(16'(data_fault), 16'h1);
        fetch(16'h8000);
        chk(16'(seg), 16'h1);
        for (c = 0; c < 4; c++) begin
            @(posedge mclk_in) code_page_select_in <= c[1:0];
            dacc(1'b0, 1'b0, 16'h8007, 16'h0);
            chk(ca, {c[1:0], 14'h3});
            chk(load_data, cw({c[1:0], 14'h3}) >> 8);
            dacc(1'b1, 1'b0, 16'hc005, 16'h0);
            chk(load_data, cw({c[1], 15'h4005}));
        end
        // Reset in mid-run: segment, widths and answers return to their reset values
        @(posedge mclk_in) arst_n_in <= 1'b0;
        #1 chk(16'(seg), 16'h1);
        chk(16'(pw), 16'h0);
        chk(load_data, 16'h0000);
        repeat (2) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        fetch(16'h0010);
        chk(16'(seg), 16'h0);
        results();
    end
endmodule // unified_memory_map_decoder_tb
`default_nettype wire

//--- hdl/umd_data_ram.sv
/*
 * Data SRAM for the decoder: two byte banks sharing one word address,
 * registered read of the whole word, per-bank write enables.
 * Assumes one clock; read and write in the same cycle see old data.
 */
`timescale 1ns/100ps
`default_nettype none
module umd_data_ram (
    input wire logic mclk_in,
    input wire logic [13:0] addr_in,
    input wire logic [1:0] bank_we_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out
);
    // ****************************************************************
    // Byte banks
    // ****************************************************************
    logic [7:0] bank_mem [2][umd_pkg::UMD_DMEM_WORDS]; // Low and high bank
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bank
            // Each bank writes its own lane and reads every cycle
            always_ff @(posedge mclk_in) begin
                if (bank_we_in[gi]) begin
                    bank_mem[gi][addr_in] <= wdata_in[gi*8 +: 8];
                end
                rdata_out[gi*8 +: 8] <= bank_mem[gi][addr_in];
            end
        end
    endgenerate
endmodule // umd_data_ram
`default_nettype wire

//--- hdl/umd_decoder.sv
/*
 * Unified memory map decoder: steers instruction fetches and data pointer
 * accesses to user code pages, utility ROM or data SRAM, and does byte
 * steering on the data SRAM, which lives inside this block.
 * Assumes the code memory and utility ROM answer one cycle after a
 * select, like the SRAM, and that the core keeps its own side of the map.
 */
// Operation
// - Program 0000-7fff is user code, ROM at 8000-9fff above it
// - Program memory is four 16k-word pages
// - Upper pages fetchable only when enable set
// - Enable set blocks ROM and data-image fetches
// - ROM run maps pages at data 8000
// - Data run maps pages at data 0000
// - Byte mode maps one page, word two
// - Page select field picks mapped pages
// - Width bit per pointer, reset parameter
// - Enable clear makes data fetchable at a000
// - User run reads ROM at data 8000
// - Executing segment never served as data
// - ROM or data execution only enable clear
// - Data run flows user code and ROM
// - Two byte banks, whole word read
// - Byte read steers byte by bit zero
// - Byte write enables only chosen bank
// - Data memory confined to words 0000-3fff
// - Utility ROM starts at program 8000
`timescale 1ns/100ps
`default_nettype none
module umd_decoder #(
    parameter logic [1:0] WIDTH_SELECT_RST = 2'h0 // Per-pointer width bit after reset
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic upper_program_enable_in,
    input wire logic [1:0] code_page_select_in,
    input wire logic [1:0] pointer_width_load_in,
    input wire logic [1:0] pointer_width_value_in,
    input wire logic data_pointer_sel_in,
    input wire umd_pkg::umd_fetch_req_s fetch_req_in,
    input wire umd_pkg::umd_data_req_s data_req_in,
    input wire logic [15:0] code_rdata_in,
    input wire logic [15:0] urom_rdata_in,
    output logic code_sel_out,
    output logic [15:0] code_addr_out,
    output logic urom_sel_out,
    output logic [12:0] urom_addr_out,
    output logic [15:0] fetch_data_out,
    output logic fetch_fault_out,
    output logic [15:0] load_data_out,
    output logic data_fault_out,
    output logic [1:0] pointer_width_out,
    output logic [1:0] segment_out
);
    // ****************************************************************
    // Pointer width bits
    // ****************************************************************
    logic [1:0] width_reg; // Byte/word select of each pointer
    logic [1:0] width_next;
    // Load any pointer's width bit on request
    assign width_next = (pointer_width_load_in & pointer_width_value_in)
                      | (~pointer_width_load_in & width_reg);
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            width_reg <= WIDTH_SELECT_RST;
        end else begin
            width_reg <= width_next;
        end
    end
    assign pointer_width_out = width_reg;

    // ****************************************************************
    // Fetch decode
    // ****************************************************************
    wire logic [15:0] f_addr = fetch_req_in.addr; // Instruction pointer
    wire logic f_low = (f_addr <= umd_pkg::UMD_USER_CODE_TOP);
    wire logic f_image = (f_addr >= umd_pkg::UMD_DATA_IMAGE_BASE); // Data image
    wire logic f_urom = !f_low && !f_image;
    wire logic up = upper_program_enable_in;
    // Upper half goes to pages two and three only when enabled
    wire logic f_upper_code = !f_low && up;
    wire logic f_code = f_low || f_upper_code;
    wire logic f_urom_ok = f_urom && !up;
    wire logic f_data_ok = f_image && !up;
    wire logic f_ok = f_code || f_urom_ok || f_data_ok;
    wire logic [13:0] f_image_off = 14'(f_addr - umd_pkg::UMD_DATA_IMAGE_BASE);

    // ****************************************************************
    // Executing segment
    // ****************************************************************
    umd_pkg::umd_segment_e seg_reg; // Segment of last accepted fetch
    umd_pkg::umd_segment_e seg_next;
    // Choose segment from the fetched region
    always_comb begin
        seg_next = seg_reg;
        if (fetch_req_in.valid && f_ok) begin
            if (f_code) begin
                seg_next = umd_pkg::UMD_SEG_USER;
            end else if (f_urom_ok) begin
                seg_next = umd_pkg::UMD_SEG_UROM;
            end else begin
                seg_next = umd_pkg::UMD_SEG_DATA;
            end
        end
    end
    // Mapping follows from the cycle after the fetch
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seg_reg <= umd_pkg::UMD_SEG_UROM;
        end else begin
            seg_reg <= seg_next;
        end
    end
    assign segment_out = seg_reg;

    // ****************************************************************
    // Data decode
    // ****************************************************************
    wire logic d_word = width_reg[data_pointer_sel_in]; // Active pointer width
    wire logic [15:0] d_ptr = data_req_in.addr;
    // Byte mode uses word address from the bits above bit zero
    wire logic [15:0] d_waddr = d_word ? d_ptr : {1'b0, d_ptr[15:1]};
    wire logic d_lane = d_ptr[0];

    // Window where code pages appear in data space
    function automatic logic [15:0] page_base(input umd_pkg::umd_segment_e s);
        page_base = (s == umd_pkg::UMD_SEG_UROM) ? umd_pkg::UMD_DATA_PAGE_HIGH
                                                  : umd_pkg::UMD_DATA_PAGE_LOW;
    endfunction
    wire logic [15:0] pg_base = page_base(seg_reg);
    // Windows sit in pointer units, so a byte pointer at 8000 is the upper half
    wire logic [15:0] pg_off = d_ptr - pg_base;
    wire logic pg_in_base = d_ptr >= pg_base;
    // Half of data space: one page of bytes or two pages of words
    wire logic pg_in_span = (pg_off[15] == 1'b0);
    wire logic [15:0] pg_woff = d_word ? pg_off : {1'b0, pg_off[15:1]}; // Word offset in window
    wire logic pg_seg = (seg_reg == umd_pkg::UMD_SEG_UROM) || (seg_reg == umd_pkg::UMD_SEG_DATA);
    wire logic d_page = data_req_in.valid && pg_seg && pg_in_base && pg_in_span;
    // Pick physical page from the select field
    wire logic [1:0] pg_num = d_word ? {code_page_select_in[1], pg_woff[14]}
                                     : code_page_select_in;
    wire logic [15:0] pg_code_addr = {pg_num, pg_woff[13:0]};

    // Utility ROM as data when not executing from it, also placed in pointer units
    wire logic [15:0] ur_off = d_ptr - umd_pkg::UMD_UROM_DATA_BASE;
    wire logic [15:0] ur_woff = d_word ? ur_off : {1'b0, ur_off[15:1]}; // ROM word offset
    wire logic ur_in = (d_ptr >= umd_pkg::UMD_UROM_DATA_BASE)
                     && ((ur_woff >> umd_pkg::UMD_UROM_AW) == 16'h0000);
    wire logic d_urom = data_req_in.valid && ur_in && !d_page
                     && (seg_reg != umd_pkg::UMD_SEG_UROM);
    // Data SRAM answers in its own low window
    wire logic sr_in = (d_waddr[15:14] == 2'h0);
    wire logic d_sram = data_req_in.valid && sr_in && !d_page
                     && (seg_reg != umd_pkg::UMD_SEG_DATA);
    wire logic d_fault = data_req_in.valid && !d_page && !d_urom && !d_sram;

    // ****************************************************************
    // Memory selects; data access has the port when both ask
    // ****************************************************************
    wire logic f_code_go = fetch_req_in.valid && f_code;
    wire logic f_urom_go = fetch_req_in.valid && f_urom_ok;
    wire logic f_sram_go = fetch_req_in.valid && f_data_ok;
    wire logic d_page_rd = d_page && !data_req_in.write; // Code memory is read-only here
    assign code_sel_out = f_code_go || d_page_rd;
    assign code_addr_out = d_page_rd ? pg_code_addr : f_addr;
    assign urom_sel_out = f_urom_go || (d_urom && !data_req_in.write);
    assign urom_addr_out = d_urom ? ur_woff[12:0] : f_addr[12:0];

    // ****************************************************************
    // Data SRAM port
    // ****************************************************************
    wire logic [13:0] sr_addr = d_sram ? d_waddr[13:0] : f_image_off;
    wire logic sr_wr = d_sram && data_req_in.write;
    // Word write hits both banks, byte write one bank by bit zero
    wire logic [1:0] sr_we = !sr_wr ? 2'h0 : d_word ? 2'h3 : (d_lane ? 2'h2 : 2'h1);
    wire logic [15:0] sr_wdata = d_word ? data_req_in.wdata
                               : {data_req_in.wdata[7:0], data_req_in.wdata[7:0]};
    logic [15:0] sr_rdata; // Whole word from both banks
    umd_data_ram u_ram (
        .mclk_in(mclk_in),
        .addr_in(sr_addr),
        .bank_we_in(sr_we),
        .wdata_in(sr_wdata),
        .rdata_out(sr_rdata)
    );

    // ****************************************************************
    // Answer steering, one cycle after the request
    // ****************************************************************
    logic [1:0] f_src_reg; // 0 code, 1 rom, 2 sram, 3 none
    logic [1:0] d_src_reg;
    logic d_byte_reg; // Last load was byte wide
    logic d_lane_reg; // Byte lane of last load
    logic f_fault_reg;
    logic d_fault_reg;
    wire logic [1:0] f_src_next = f_code_go ? 2'h0 : f_urom_go ? 2'h1 : f_sram_go ? 2'h2 : 2'h3;
    wire logic [1:0] d_src_next = d_page ? 2'h0 : d_urom ? 2'h1 : d_sram ? 2'h2 : 2'h3;
    // Remember where each answer comes from
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            f_src_reg <= 2'h3;
            d_src_reg <= 2'h3;
            d_byte_reg <= 1'b0;
            d_lane_reg <= 1'b0;
            f_fault_reg <= 1'b0;
            d_fault_reg <= 1'b0;
        end else begin
            f_src_reg <= f_src_next;
            d_src_reg <= d_src_next;
            d_byte_reg <= !d_word;
            d_lane_reg <= d_lane;
            f_fault_reg <= fetch_req_in.valid && !f_ok;
            d_fault_reg <= d_fault;
        end
    end

    // Select a word by source
    function automatic logic [15:0] pick(input logic [1:0] s, input logic [15:0] c,
                                         input logic [15:0] u, input logic [15:0] r);
        case (s)
            2'h0: pick = c;
            2'h1: pick = u;
            2'h2: pick = r;
            default: pick = 16'h0000;
        endcase
    endfunction
    // Code port serves data first, so a clashing fetch reads the data access's word without a fault
    wire logic [15:0] f_word = pick(f_src_reg, code_rdata_in, urom_rdata_in, sr_rdata);
    wire logic [15:0] d_word_rd = pick(d_src_reg, code_rdata_in, urom_rdata_in, sr_rdata);
    // Byte load picks the lane by pointer bit zero
    wire logic [7:0] d_byte_rd = d_lane_reg ? d_word_rd[15:8] : d_word_rd[7:0];
    assign fetch_data_out = f_word;
    assign fetch_fault_out = f_fault_reg;
    assign load_data_out = d_byte_reg ? {8'h00, d_byte_rd} : d_word_rd;
    assign data_fault_out = d_fault_reg;
    // Code words stored by byte must sit at even byte addresses
endmodule // umd_decoder
`default_nettype wire

//--- include/umd_pkg.sv
/*
 * Package for the unified memory map decoder: address windows, page layout,
 * segment enumeration and packed fetch and data request carriers.
 * Assumes a 16-bit word program bus and 16-bit byte/word data pointers.
 */
`default_nettype none
package umd_pkg;
    // ****************************************************************
    // Address windows and page layout
    // ****************************************************************
    localparam logic [15:0] UMD_USER_CODE_BASE = 16'h0000; // Lower user code
    localparam logic [15:0] UMD_USER_CODE_TOP = 16'h7fff; // End of lower user code
    localparam logic [15:0] UMD_UROM_BASE = 16'h8000; // Utility ROM in program space
    localparam logic [15:0] UMD_DATA_IMAGE_BASE = 16'ha000; // Data memory seen as code
    localparam logic [15:0] UMD_DATA_PAGE_HIGH = 16'h8000; // Pages mapped from ROM run
    localparam logic [15:0] UMD_DATA_PAGE_LOW = 16'h0000; // Pages mapped from data run
    localparam logic [15:0] UMD_UROM_DATA_BASE = 16'h8000; // Utility ROM in data space
    localparam int UMD_PAGE_WORDS = 16384; // Words in one program page
    localparam int UMD_PAGE_AW = 14; // Address bits inside one page
    localparam int UMD_PAGE_COUNT = 4; // Physical code pages
    localparam int UMD_UROM_AW = 13; // Utility ROM word address width
    localparam int UMD_DMEM_AW = 14; // Data memory word address width
    localparam int UMD_DMEM_WORDS = 16384; // Data memory depth in words
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic UMD_UPPER_ENABLE_RST = 1'b0; // Upper pages off after reset
    localparam logic [1:0] UMD_SEGMENT_RST_SEL = 2'h1; // Run from utility ROM at reset
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        UMD_SEG_USER,
        UMD_SEG_UROM,
        UMD_SEG_DATA,
        UMD_SEG_NONE
    } umd_segment_e;

    typedef struct packed {
        logic valid; // Data access request
        logic write; // Store when set
        logic pointer_width_select; // 0 byte, 1 word
        logic [15:0] addr; // Pointer value
        logic [15:0] wdata; // Store data, byte in low lane
    } umd_data_req_s;

    typedef struct packed {
        logic valid; // Fetch request
        logic [15:0] addr; // Instruction pointer
    } umd_fetch_req_s;
endpackage
`default_nettype wire
